/* rtl/uafmp_top.sv */
// Autoflow control, modem pins and loopback routing for one serial channel
// Operation
// - Rising ring indicate raises modem status interrupt when enabled. Code raises it when RING_INDICATE_N rises, i.e. when ring indicate ends.
// - Ring indicate level readable in modem status register.
// - Modem control bit 1 set drives RTS pin low.
// - RTS pin high after reset.
// - RTS affects flow only with auto-RTS feature bit 6 set.
// - Loopback ignores RX pin and routes TX to receiver.
// - Receive ready goes low at trigger level or timeout.
// - Receive ready goes high when FIFO empty or holds error.
// - Transmit ready low with trigger spaces free, high when full.
// - Auto-CTS samples CTS before each byte, starts only when active.
// - CTS changes raise no interrupt while flow control enabled.
// - Without auto-CTS transmitter sends regardless of CTS.
// - Auto-RTS drops RTS when fill reaches trigger 1, 4 or 8.
// - Trigger 1, 4, 8: RTS reasserted once FIFO emptied.
// - Trigger 14: RTS drops at first data bit of 16th char.
// - Trigger 14: RTS reasserted when one byte space free.
// - Autoflow when modem control bits 5 and 1 both set; here auto-CTS needs bit 5 or feature bit 7, auto-RTS also feature bit 6.
// - One extra byte after RTS drop is no violation.
// - Reset clears registers and outputs, disables TX and RX.
//
// Added by the designer: the register addresses and register access over Avalon-MM.
`default_nettype none
module uafmp_top #(
    parameter int FIFO_CNT_W = 5
) (
    input  wire logic                  CLK_SYS,
    input  wire logic                  RST,
    input  wire logic [3:0]            AVS_ADDRESS,
    input  wire logic                  AVS_READ,
    input  wire logic                  AVS_WRITE,
    input  wire logic [31:0]           AVS_WRITEDATA,
    output logic      [31:0]           AVS_READDATA,
    output logic                       AVS_WAITREQUEST,
    input  wire logic                  RING_INDICATE_N,
    input  wire logic                  CTS_N,
    input  wire logic                  RX_PIN,
    output logic                       RTS_N,
    output logic                       TX_PIN,
    input  wire logic                  CORE_TX_DATA,
    output logic                       CORE_RX_DATA,
    input  wire logic                  TX_BYTE_REQ,
    output logic                       TX_BYTE_GO,
    input  wire logic [FIFO_CNT_W-1:0] RX_FIFO_COUNT,
    input  wire logic [FIFO_CNT_W-1:0] TX_FIFO_COUNT,
    input  wire logic                  RX_TIMEOUT,
    input  wire logic                  RX_FIFO_ERROR,
    input  wire logic                  RX_FIRST_DATA_BIT,
    input  wire logic                  MSI_ENABLE,
    output logic                       RECEIVE_READY_OUT_N,
    output logic                       TRANSMIT_READY_OUT_N,
    output logic                       MODEM_IRQ
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] ri_sync_reg;
    logic [2:0] cts_sync_reg;
    logic [2:0] rx_sync_reg;
    logic       ri_level_reg;
    logic       cts_level_reg;
    logic       rx_level_reg;

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            ri_sync_reg  <= 3'h7;
            cts_sync_reg <= 3'h7;
            rx_sync_reg  <= 3'h7;
        end else begin
            ri_sync_reg  <= {ri_sync_reg[1:0], RING_INDICATE_N};
            cts_sync_reg <= {cts_sync_reg[1:0], CTS_N};
            rx_sync_reg  <= {rx_sync_reg[1:0], RX_PIN};
        end
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            ri_level_reg  <= 1'b1;
            cts_level_reg <= 1'b1;
            rx_level_reg  <= 1'b1;
        end else begin
            if (ri_sync_reg[1] == ri_sync_reg[2]) begin
                ri_level_reg <= ri_sync_reg[2];
            end
            if (cts_sync_reg[1] == cts_sync_reg[2]) begin
                cts_level_reg <= cts_sync_reg[2];
            end
            if (rx_sync_reg[1] == rx_sync_reg[2]) begin
                rx_level_reg <= rx_sync_reg[2];
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] mcr_reg;
    logic [7:0] efr_reg;
    logic [7:0] fcfg_reg;
    logic       ri_prev_reg;
    logic       cts_prev_reg;
    logic       teri_reg;
    logic       dcts_reg;
    logic       wait_reg;
    logic       msr_read;
    logic       rise_ri;
    logic       cts_chg;
    logic       auto_rts;
    logic       auto_cts;
    logic       flow_on;
    logic [4:0] trig_lvl;
    logic [4:0] tx_trig;

    assign msr_read = AVS_READ && !wait_reg && AVS_ADDRESS == uafmp_pkg::ADDR_MODEM_STAT;
    assign rise_ri  = !ri_prev_reg && ri_level_reg;
    assign cts_chg  = cts_prev_reg != cts_level_reg;
    assign flow_on  = mcr_reg[uafmp_pkg::MCR_AFE_BIT];
    assign auto_rts = flow_on && mcr_reg[uafmp_pkg::MCR_RTS_BIT]
                      && efr_reg[uafmp_pkg::EFR_AUTO_RTS_BIT];
    assign auto_cts = flow_on || efr_reg[uafmp_pkg::EFR_AUTO_CTS_BIT];

    always_comb begin
        unique case (fcfg_reg[1:0])
            2'h0: trig_lvl = uafmp_pkg::TRIG_LVL_1;
            2'h1: trig_lvl = uafmp_pkg::TRIG_LVL_4;
            2'h2: trig_lvl = uafmp_pkg::TRIG_LVL_8;
            2'h3: trig_lvl = uafmp_pkg::TRIG_LVL_14;
        endcase
        unique case (fcfg_reg[5:4])
            2'h0: tx_trig = uafmp_pkg::TRIG_LVL_1;
            2'h1: tx_trig = uafmp_pkg::TRIG_LVL_4;
            2'h2: tx_trig = uafmp_pkg::TRIG_LVL_8;
            2'h3: tx_trig = uafmp_pkg::TRIG_LVL_14;
        endcase
    end

    // Bus slave: one wait cycle per access
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            wait_reg <= 1'b1;
        end else if ((AVS_READ || AVS_WRITE) && wait_reg) begin
            wait_reg <= 1'b0;
        end else begin
            wait_reg <= 1'b1;
        end
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            mcr_reg  <= uafmp_pkg::MCR_RESET;
            efr_reg  <= uafmp_pkg::EFR_RESET;
            fcfg_reg <= uafmp_pkg::FCFG_RESET;
        end else if (AVS_WRITE && !wait_reg) begin
            unique case (AVS_ADDRESS)
                uafmp_pkg::ADDR_MODEM_CTRL: mcr_reg  <= AVS_WRITEDATA[7:0];
                uafmp_pkg::ADDR_FEATURE:    efr_reg  <= AVS_WRITEDATA[7:0];
                uafmp_pkg::ADDR_FIFO_CFG:   fcfg_reg <= AVS_WRITEDATA[7:0];
                default: ;
            endcase
        end
    end

    // Delta flags: set wins over clear on read
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            ri_prev_reg  <= 1'b1;
            cts_prev_reg <= 1'b1;
            teri_reg     <= 1'b0;
            dcts_reg     <= 1'b0;
        end else begin
            ri_prev_reg  <= ri_level_reg;
            cts_prev_reg <= cts_level_reg;
            if (rise_ri) begin
                teri_reg <= 1'b1;
            end else if (msr_read) begin
                teri_reg <= 1'b0;
            end
            if (cts_chg && !auto_cts) begin
                dcts_reg <= 1'b1;
            end else if (msr_read) begin
                dcts_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            MODEM_IRQ <= 1'b0;
        end else begin
            MODEM_IRQ <= MSI_ENABLE && (teri_reg || dcts_reg);
        end
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            AVS_READDATA    <= 32'h0000_0000;
            AVS_WAITREQUEST <= 1'b1;
        end else begin
            AVS_WAITREQUEST <= !((AVS_READ || AVS_WRITE) && wait_reg);
            AVS_READDATA    <= 32'h0000_0000;
            if (AVS_READ && wait_reg) begin
                unique case (AVS_ADDRESS)
                    uafmp_pkg::ADDR_MODEM_CTRL: AVS_READDATA <= {24'h00_0000, mcr_reg};
                    uafmp_pkg::ADDR_MODEM_STAT: AVS_READDATA <= {24'h00_0000, 1'b0, !ri_level_reg,
                                                1'b0, !cts_level_reg, 1'b0, teri_reg, 1'b0,
                                                dcts_reg};
                    uafmp_pkg::ADDR_FEATURE:    AVS_READDATA <= {24'h00_0000, efr_reg};
                    uafmp_pkg::ADDR_FIFO_CFG:   AVS_READDATA <= {24'h00_0000, fcfg_reg};
                    uafmp_pkg::ADDR_FIFO_STAT:  AVS_READDATA <= {30'h0000_0000, TRANSMIT_READY_OUT_N,
                                                RECEIVE_READY_OUT_N};
                    default:                    AVS_READDATA <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Auto-RTS
    // ------------------------------------------------------------
    logic       rts_hold_reg;
    logic [4:0] rx_cnt;

    assign rx_cnt = 5'(RX_FIFO_COUNT);

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            rts_hold_reg <= 1'b0;
        end else if (!auto_rts) begin
            rts_hold_reg <= 1'b0;
        end else if (trig_lvl == uafmp_pkg::TRIG_LVL_14) begin
            if (rx_cnt < uafmp_pkg::FIFO_DEPTH) begin
                rts_hold_reg <= 1'b0;
            end
            if (RX_FIRST_DATA_BIT && rx_cnt == uafmp_pkg::FIFO_DEPTH - 5'h01) begin
                rts_hold_reg <= 1'b1;
            end
        end else begin
            if (rx_cnt >= trig_lvl) begin
                rts_hold_reg <= 1'b1;
            end else if (rx_cnt == 5'h00) begin
                rts_hold_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            RTS_N <= 1'b1;
        end else begin
            RTS_N <= !(mcr_reg[uafmp_pkg::MCR_RTS_BIT] && !(auto_rts && rts_hold_reg));
        end
    end

    // ------------------------------------------------------------
    // Auto-CTS transmit gate and loopback
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            TX_BYTE_GO <= 1'b0;
        end else begin
            TX_BYTE_GO <= TX_BYTE_REQ && (!auto_cts || !cts_level_reg);
        end
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            TX_PIN       <= 1'b1;
            CORE_RX_DATA <= 1'b1;
        end else if (mcr_reg[uafmp_pkg::MCR_LOOP_BIT]) begin
            TX_PIN       <= 1'b1;
            CORE_RX_DATA <= CORE_TX_DATA;
        end else begin
            TX_PIN       <= CORE_TX_DATA;
            CORE_RX_DATA <= rx_level_reg;
        end
    end

    // ------------------------------------------------------------
    // Ready outputs
    // ------------------------------------------------------------
    logic [4:0] tx_free;
    assign tx_free = uafmp_pkg::FIFO_DEPTH - 5'(TX_FIFO_COUNT);

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            RECEIVE_READY_OUT_N  <= 1'b1;
            TRANSMIT_READY_OUT_N <= 1'b1;
        end else begin
            if (rx_cnt == 5'h00 || RX_FIFO_ERROR) begin
                RECEIVE_READY_OUT_N <= 1'b1;
            end else if (rx_cnt >= trig_lvl || RX_TIMEOUT) begin
                RECEIVE_READY_OUT_N <= 1'b0;
            end
            if (tx_free == 5'h00) begin
                TRANSMIT_READY_OUT_N <= 1'b1;
            end else if (tx_free >= tx_trig) begin
                TRANSMIT_READY_OUT_N <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_rts_manual: assert property (@(posedge CLK_SYS) disable iff (RST)
        (!auto_rts && mcr_reg[uafmp_pkg::MCR_RTS_BIT]) |=> !RTS_N)
        else $error("RTS not low with bit set");
    a_rts_clear: assert property (@(posedge CLK_SYS) disable iff (RST)
        !mcr_reg[uafmp_pkg::MCR_RTS_BIT] |=> RTS_N)
        else $error("RTS low with bit clear");
    a_rts_trig: assert property (@(posedge CLK_SYS) disable iff (RST)
        (auto_rts && trig_lvl != uafmp_pkg::TRIG_LVL_14 && rx_cnt >= trig_lvl) |=> ##1 RTS_N)
        else $error("RTS not dropped at trigger");
    a_cts_gate: assert property (@(posedge CLK_SYS) disable iff (RST)
        (auto_cts && cts_level_reg) |=> !TX_BYTE_GO)
        else $error("Byte started with CTS inactive");
    a_cts_free: assert property (@(posedge CLK_SYS) disable iff (RST)
        (!auto_cts && TX_BYTE_REQ) |=> TX_BYTE_GO)
        else $error("Byte held without auto-CTS");
    a_no_dcts: assert property (@(posedge CLK_SYS) disable iff (RST)
        (auto_cts && !dcts_reg) |=> !dcts_reg)
        else $error("CTS delta set under flow control");
    a_ri_irq: assert property (@(posedge CLK_SYS) disable iff (RST)
        (rise_ri && MSI_ENABLE) |=> ##1 (MODEM_IRQ || !MSI_ENABLE))
        else $error("Ring rise gave no interrupt");
    a_loop_route: assert property (@(posedge CLK_SYS) disable iff (RST)
        mcr_reg[uafmp_pkg::MCR_LOOP_BIT] |=> (CORE_RX_DATA == $past(CORE_TX_DATA) && TX_PIN))
        else $error("Loopback routing wrong");
    a_receive_ready_out_n_empty: assert property (@(posedge CLK_SYS) disable iff (RST)
        (rx_cnt == 5'h00) |=> RECEIVE_READY_OUT_N)
        else $error("Receive ready low when empty");
    a_transmit_ready_out_n_full: assert property (@(posedge CLK_SYS) disable iff (RST)
        (tx_free == 5'h00) |=> TRANSMIT_READY_OUT_N)
        else $error("Transmit ready low when full");
    a_ri_flag: assert property (@(posedge CLK_SYS) disable iff (RST)
        rise_ri |=> teri_reg)
        else $error("Ring flag not set");
    a_irq_follow: assert property (@(posedge CLK_SYS) disable iff (RST)
        (MSI_ENABLE && (teri_reg || dcts_reg)) |=> MODEM_IRQ)
        else $error("Modem interrupt missing");
    a_msr_ring: assert property (@(posedge CLK_SYS) disable iff (RST)
        msr_read |-> (AVS_READDATA[uafmp_pkg::MSR_RI_BIT] != $past(ri_level_reg)))
        else $error("Ring level not in status");
    a_msr_cts: assert property (@(posedge CLK_SYS) disable iff (RST)
        msr_read |-> (AVS_READDATA[uafmp_pkg::MSR_CTS_BIT] != $past(cts_level_reg)))
        else $error("CTS level not in status");
    a_dcts_set: assert property (@(posedge CLK_SYS) disable iff (RST)
        (cts_chg && !auto_cts) |=> dcts_reg)
        else $error("CTS delta not set");
    a_rts_empty: assert property (@(posedge CLK_SYS) disable iff (RST)
        (auto_rts && trig_lvl != uafmp_pkg::TRIG_LVL_14 && rx_cnt == 5'h00)
        |=> ##1 (!RTS_N || !mcr_reg[uafmp_pkg::MCR_RTS_BIT]))
        else $error("RTS not back when empty");
    a_rts_first: assert property (@(posedge CLK_SYS) disable iff (RST)
        (auto_rts && trig_lvl == uafmp_pkg::TRIG_LVL_14 && RX_FIRST_DATA_BIT
        && rx_cnt == uafmp_pkg::FIFO_DEPTH - 5'h01) |=> rts_hold_reg)
        else $error("RTS not held at last char");
    a_rts_space: assert property (@(posedge CLK_SYS) disable iff (RST)
        (auto_rts && trig_lvl == uafmp_pkg::TRIG_LVL_14 && !RX_FIRST_DATA_BIT
        && rx_cnt < uafmp_pkg::FIFO_DEPTH) |=> !rts_hold_reg)
        else $error("RTS held with space free");
    a_receive_ready_out_n_trig: assert property (@(posedge CLK_SYS) disable iff (RST)
        (rx_cnt != 5'h00 && !RX_FIFO_ERROR && (rx_cnt >= trig_lvl || RX_TIMEOUT))
        |=> !RECEIVE_READY_OUT_N)
        else $error("Receive ready not low");
    a_receive_ready_out_n_err: assert property (@(posedge CLK_SYS) disable iff (RST)
        RX_FIFO_ERROR |=> RECEIVE_READY_OUT_N)
        else $error("Receive ready low on error");
    a_transmit_ready_out_n_space: assert property (@(posedge CLK_SYS) disable iff (RST)
        (tx_free != 5'h00 && tx_free >= tx_trig) |=> !TRANSMIT_READY_OUT_N)
        else $error("Transmit ready not low");
    a_tx_direct: assert property (@(posedge CLK_SYS) disable iff (RST)
        !mcr_reg[uafmp_pkg::MCR_LOOP_BIT] |=> (TX_PIN == $past(CORE_TX_DATA)))
        else $error("Transmit pin not following core");
    a_rx_direct: assert property (@(posedge CLK_SYS) disable iff (RST)
        !mcr_reg[uafmp_pkg::MCR_LOOP_BIT] |=> (CORE_RX_DATA == $past(rx_level_reg)))
        else $error("Receive data not from pin");

endmodule
`default_nettype wire

/* common/uafmp_pkg.sv */
// Constants and register map for the autoflow and modem pin block
`default_nettype none
package uafmp_pkg;
    localparam logic [3:0] ADDR_MODEM_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_MODEM_STAT   = 4'h1;
    localparam logic [3:0] ADDR_FEATURE      = 4'h2;
    localparam logic [3:0] ADDR_FIFO_CFG     = 4'h3;
    localparam logic [3:0] ADDR_FIFO_STAT    = 4'h4;
    localparam int         MCR_RTS_BIT       = 1;
    localparam int         MCR_LOOP_BIT      = 4;
    localparam int         MCR_AFE_BIT       = 5;
    localparam int         EFR_AUTO_RTS_BIT  = 6;
    localparam int         EFR_AUTO_CTS_BIT  = 7;
    localparam int         MSR_DCTS_BIT      = 0;
    localparam int         MSR_TERI_BIT      = 2;
    localparam int         MSR_CTS_BIT       = 4;
    localparam int         MSR_RI_BIT        = 6;
    localparam logic [7:0] MCR_RESET         = 8'h00;
    localparam logic [7:0] EFR_RESET         = 8'h00;
    localparam logic [7:0] FCFG_RESET        = 8'h00;
    localparam logic [4:0] FIFO_DEPTH        = 5'h10;
    localparam logic [4:0] TRIG_LVL_1        = 5'h01;
    localparam logic [4:0] TRIG_LVL_4        = 5'h04;
    localparam logic [4:0] TRIG_LVL_8        = 5'h08;
    localparam logic [4:0] TRIG_LVL_14       = 5'h0e;
    localparam int         SYNC_STAGES       = 3;
endpackage
`default_nettype wire

/* tb/uafmp_remote.sv */
// Remote serial device model driving CTS and the receive line
`default_nettype none
module uafmp_remote (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic rts_n,
    input  wire logic cts_want,
    input  wire logic send,
    input  wire logic data,
    output logic      cts_n,
    output logic      rx_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // --------------------------------
    // Clear to send, moved on edges only
    // --------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cts_n <= 1'b1;
        end else begin
            cts_n <= ~cts_want;
        end
    end
    // --------------------------------
    // Line idles high, sends only while RTS asserted
    // --------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_pin <= 1'b1;
        end else begin
            rx_pin <= (send && !rts_n) ? data : 1'b1;
        end
    end
endmodule
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench for the autoflow and modem pin block
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    // --------------------------------
    // Signals and instances
    // --------------------------------
    logic        clk_sys, rst, avs_read, avs_write, ri_n, core_tx, req, rx_tmo, rx_err;
    logic        first_bit, msi_en, cts_want, send, data, waitreq, rts_n, tx_pin, core_rx;
    logic        tx_go, rrdy_n, trdy_n, irq, cts_n, rx_pin;
    logic [3:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd, lfsr;
    logic [4:0]  rx_cnt, tx_cnt, tr, tt;
    int          err_count, samples_checked;
    uafmp_top dut (
        .CLK_SYS(clk_sys), .RST(rst), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
        .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_READDATA(avs_readdata),
        .AVS_WAITREQUEST(waitreq), .RING_INDICATE_N(ri_n), .CTS_N(cts_n), .RX_PIN(rx_pin),
        .RTS_N(rts_n), .TX_PIN(tx_pin), .CORE_TX_DATA(core_tx), .CORE_RX_DATA(core_rx),
        .TX_BYTE_REQ(req), .TX_BYTE_GO(tx_go), .RX_FIFO_COUNT(rx_cnt), .TX_FIFO_COUNT(tx_cnt),
        .RX_TIMEOUT(rx_tmo), .RX_FIFO_ERROR(rx_err), .RX_FIRST_DATA_BIT(first_bit),
        .MSI_ENABLE(msi_en), .RECEIVE_READY_OUT_N(rrdy_n), .TRANSMIT_READY_OUT_N(trdy_n),
        .MODEM_IRQ(irq)
    );
    uafmp_remote remote (.clk(clk_sys), .rst(rst), .rts_n(rts_n), .cts_want(cts_want),
        .send(send), .data(data), .cts_n(cts_n), .rx_pin(rx_pin));
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // --------------------------------
    // Helpers
    // --------------------------------
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [4:0] trig(input logic [1:0] c);
        case (c)
            2'h0: return 5'h01;
            2'h1: return 5'h04;
            2'h2: return 5'h08;
            default: return 5'h0e;
        endcase
    endfunction
    task automatic check_bit(input string n, input logic e, input logic g);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %s expected %0b seen %0b", n, e, g);
        end
    endtask
    task automatic check_word(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic settle();
        repeat (10) @(posedge clk_sys);
    endtask
    task automatic bus(input logic [3:0] a, input logic w, input logic [7:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_write <= w;
        avs_read <= ~w;
        do begin
            @(posedge clk_sys);
            n++;
        end while (waitreq !== 1'b0 && n < 40);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        check_bit("waitreq", 1'b0, waitreq);
        @(posedge clk_sys);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus(a, 1'b1, d);
    endtask
    task automatic rd_chk(input string n, input logic [3:0] a, input logic [31:0] e);
        bus(a, 1'b0, 8'h00);
        check_word(n, e, rd);
    endtask
    task automatic cnt_chk(input logic [4:0] c, input logic e);
        rx_cnt <= c;
        settle();
        check_bit("rts_n", e, rts_n);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_count++;
        $display("ERROR watchdog expected done seen hang");
        complete_run();
    end
    // --------------------------------
    // Tests
    // --------------------------------
    initial begin
        {avs_read, avs_write, core_tx, req, rx_tmo, rx_err, first_bit, msi_en} = '0;
        {cts_want, send, data} = '0;
        {rx_cnt, tx_cnt} = '0;
        avs_address = '0;
        avs_writedata = '0;
        ri_n = 1'b1;
        rst = 1'b1;
        lfsr = 32'hdf2d;
        err_count = 0;
        samples_checked = 0;
        repeat (2) @(posedge clk_sys);
        check_bit("rts_n", 1'b1, rts_n);
        check_bit("tx_pin", 1'b1, tx_pin);
        check_bit("ready", 1'b1, rrdy_n & trdy_n);
        check_bit("irq_go", 1'b0, irq | tx_go);
        rst <= 1'b0;
        @(posedge clk_sys);
        rd_chk("mcr", uafmp_pkg::ADDR_MODEM_CTRL, {24'h0, uafmp_pkg::MCR_RESET});
        rd_chk("efr", uafmp_pkg::ADDR_FEATURE, {24'h0, uafmp_pkg::EFR_RESET});
        wr(4'hf, 8'hff);
        rd_chk("unmapped", 4'hf, 32'h0);
        $display("test reset done");
        wr(uafmp_pkg::ADDR_MODEM_CTRL, 8'h02);
        settle();
        check_bit("rts_n", 1'b0, rts_n);
        wr(uafmp_pkg::ADDR_MODEM_CTRL, 8'h00);
        settle();
        check_bit("rts_n", 1'b1, rts_n);
        msi_en <= 1'b1;
        ri_n <= 1'b0;
        settle();
        check_bit("irq", 1'b0, irq);
        rd_chk("msr", uafmp_pkg::ADDR_MODEM_STAT, 32'h40);
        ri_n <= 1'b1;
        settle();
        check_bit("irq", 1'b1, irq);
        rd_chk("msr", uafmp_pkg::ADDR_MODEM_STAT, 32'h04);
        @(posedge clk_sys);
        check_bit("irq", 1'b0, irq);
        msi_en <= 1'b0;
        ri_n <= 1'b0;
        settle();
        ri_n <= 1'b1;
        settle();
        check_bit("irq", 1'b0, irq);
        rd_chk("msr", uafmp_pkg::ADDR_MODEM_STAT, 32'h04);
        $display("test ring done");
        req <= 1'b1;
        msi_en <= 1'b1;
        settle();
        check_bit("tx_go", 1'b1, tx_go);
        wr(uafmp_pkg::ADDR_FEATURE, 8'h80);
        settle();
        check_bit("tx_go", 1'b0, tx_go);
        cts_want <= 1'b1;
        settle();
        check_bit("tx_go", 1'b1, tx_go);
        check_bit("irq", 1'b0, irq);
        rd_chk("msr", uafmp_pkg::ADDR_MODEM_STAT, 32'h10);
        wr(uafmp_pkg::ADDR_FEATURE, 8'h00);
        wr(uafmp_pkg::ADDR_MODEM_CTRL, 8'h20);
        cts_want <= 1'b0;
        settle();
        check_bit("tx_go", 1'b0, tx_go);
        wr(uafmp_pkg::ADDR_MODEM_CTRL, 8'h00);
        cts_want <= 1'b1;
        settle();
        check_bit("irq", 1'b1, irq);
        rd_chk("msr", uafmp_pkg::ADDR_MODEM_STAT, 32'h11);
        msi_en <= 1'b0;
        $display("test cts done");
        wr(uafmp_pkg::ADDR_MODEM_CTRL, 8'h22);
        wr(uafmp_pkg::ADDR_FEATURE, 8'h40);
        for (int c = 0; c < 3; c++) begin
            tr = trig(c[1:0]);
            wr(uafmp_pkg::ADDR_FIFO_CFG, {6'h0, c[1:0]});
            cnt_chk(tr - 5'h01, 1'b0);
            cnt_chk(tr, 1'b1);
            cnt_chk(tr + 5'h01, 1'b1);
            cnt_chk(5'h01, 1'b1);
            cnt_chk(5'h00, 1'b0);
        end
        wr(uafmp_pkg::ADDR_FIFO_CFG, 8'h03);
        cnt_chk(5'h0e, 1'b0);
        cnt_chk(5'h0f, 1'b0);
        first_bit <= 1'b1;
        @(posedge clk_sys);
        first_bit <= 1'b0;
        cnt_chk(5'h10, 1'b1);
        cnt_chk(5'h0f, 1'b0);
        wr(uafmp_pkg::ADDR_FEATURE, 8'h00);
        cnt_chk(5'h10, 1'b0);
        $display("test autorts done");
        for (int i = 0; i < 3; i++) begin
            lfsr = lfsr_next(lfsr);
            tr = trig(lfsr[1:0]);
            tt = trig(lfsr[5:4]);
            wr(uafmp_pkg::ADDR_FIFO_CFG, {2'h0, lfsr[5:4], 2'h0, lfsr[1:0]});
            rx_cnt <= tr;
            tx_cnt <= 5'h10 - tt;
            settle();
            check_bit("rrdy_n", 1'b0, rrdy_n);
            check_bit("trdy_n", 1'b0, trdy_n);
            rx_err <= 1'b1;
            tx_cnt <= 5'h10;
            settle();
            check_bit("rrdy_n", 1'b1, rrdy_n);
            check_bit("trdy_n", 1'b1, trdy_n);
            rx_err <= 1'b0;
            rx_cnt <= 5'h00;
            settle();
            check_bit("rrdy_n", 1'b1, rrdy_n);
            rx_tmo <= 1'b1;
            rx_cnt <= 5'h01;
            settle();
            check_bit("rrdy_n", 1'b0, rrdy_n);
            rd_chk("status", uafmp_pkg::ADDR_FIFO_STAT, 32'h2);
            rx_tmo <= 1'b0;
        end
        $display("test ready done");
        send <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            lfsr = lfsr_next(lfsr);
            wr(uafmp_pkg::ADDR_MODEM_CTRL, {3'h0, i[0], 4'h2});
            core_tx <= lfsr[0];
            data <= lfsr[1];
            settle();
            check_bit("core_rx", i[0] ? lfsr[0] : lfsr[1], core_rx);
            check_bit("tx_pin", i[0] | lfsr[0], tx_pin);
        end
        send <= 1'b0;
        $display("test loopback done");
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        check_bit("rts_n", 1'b1, rts_n);
        rst <= 1'b0;
        @(posedge clk_sys);
        rd_chk("mcr", uafmp_pkg::ADDR_MODEM_CTRL, 32'h0);
        $display("test second reset done");
        complete_run();
    end
endmodule
`default_nettype wire
